// file: hw/cisu_pkg.sv
/*
 cisu_pkg: constants, register offsets and carrier types of the interrupt and stack unit.
 assumes an 8-bit core on one 40 MHz clock with byte-wide i/o access.
*/
package cisu_pkg;
	localparam int PC_W = 12;
	localparam int IDX_W = 3;
	localparam logic [5:0] IO_SP_LOW = 6'h10;
	localparam logic [5:0] IO_SP_HIGH = 6'h11;
	localparam logic [5:0] IO_STATUS = 6'h12;
	localparam logic [5:0] IO_GEN_CTRL = 6'h13;
	localparam logic [5:0] IO_IRQ_EN = 6'h14;
	localparam logic [5:0] IO_IRQ_FLAG = 6'h15;
	localparam int GIE_BIT = 7;
	localparam int VSEL_BIT = 1;
	localparam int ZERO_BIT = 1;
	localparam int CARRY_BIT = 0;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [15:0] SP_BYTE_STEP = 16'h0001;
	localparam logic [PC_W-1:0] APP_START = 12'h000;
	localparam logic [PC_W-1:0] VEC_STEP = 12'h001;
	localparam logic [2:0] ENTRY_CYC = 3'h4;
	localparam logic [2:0] RETURN_CYC = 3'h4;
	localparam logic [2:0] WAKE_EXTRA_CYC = 3'h4;
	localparam logic [4:0] PTR_BASE = 5'h1a;
	localparam logic [15:0] PTR_STEP = 16'h0001;

	typedef enum logic [2:0] {
		ALU_ADD = 3'h0,
		ALU_SUB = 3'h1,
		ALU_AND = 3'h2,
		ALU_OR = 3'h3,
		ALU_XOR = 3'h4,
		ALU_MOV = 3'h5,
		ALU_LDI = 3'h6
	} cisu_alu_op_type;

	typedef enum logic [1:0] {
		AGU_PLAIN = 2'h0,
		AGU_DISP = 2'h1,
		AGU_POSTINC = 2'h2,
		AGU_PREDEC = 2'h3
	} cisu_agu_mode_type;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [5:0] addr;
		logic [7:0] wdata;
	} cisu_io_req_type;

	typedef struct packed {
		logic push;
		logic pop;
		logic call;
		logic ret;
		logic interrupt_return_instruction;
		logic sei;
		logic cli;
	} cisu_op_type;

	typedef struct packed {
		logic we;
		logic re;
		logic [15:0] addr;
		logic [7:0] wdata;
	} cisu_mem_type;

	typedef struct packed {
		logic en;
		cisu_alu_op_type op;
		logic [4:0] dst;
		logic [4:0] src;
		logic [7:0] imm;
	} cisu_alu_req_type;

	typedef struct packed {
		logic en;
		logic [1:0] sel;
		cisu_agu_mode_type mode;
		logic [5:0] disp;
	} cisu_agu_req_type;

	typedef struct packed {
		logic en;
		logic [1:0] sel;
		logic [15:0] value;
	} cisu_ptr_wr_type;

	typedef logic [2:0][15:0] cisu_ptrs_type;
endpackage : cisu_pkg

// file: hw/cisu_regs.sv
/*
 cisu_regs: 32-byte working register file with a single-cycle alu write-back.
 assumes one alu request per cycle; a pointer write-back wins over the alu on pointer_register_pairs.
*/
`timescale 1ns/1ps
module cisu_regs
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input cisu_pkg::cisu_alu_req_type alu_i,
	input cisu_pkg::cisu_ptr_wr_type ptr_wr_i,
	output logic zero_o,
	output logic carry_o,
	output cisu_pkg::cisu_ptrs_type ptrs_o
);
	import cisu_pkg::*;

	logic [7:0] regs [32];
	logic [7:0] next_regs [32];
	logic [8:0] sum;
	logic [4:0] lo_idx;

	always_comb
	begin
		next_regs = regs;
		sum = {1'b0, BYTE_ZERO};
		case (alu_i.op)
			ALU_ADD: sum = {1'b0, regs[alu_i.dst]} + {1'b0, regs[alu_i.src]};
			ALU_SUB: sum = {1'b0, regs[alu_i.dst]} - {1'b0, regs[alu_i.src]};
			ALU_AND: sum = {1'b0, regs[alu_i.dst] & regs[alu_i.src]};
			ALU_OR: sum = {1'b0, regs[alu_i.dst] | regs[alu_i.src]};
			ALU_XOR: sum = {1'b0, regs[alu_i.dst] ^ regs[alu_i.src]};
			ALU_MOV: sum = {1'b0, regs[alu_i.src]};
			ALU_LDI: sum = {1'b0, alu_i.imm};
			default: sum = {1'b0, BYTE_ZERO};
		endcase
		if (alu_i.en)
			next_regs[alu_i.dst] = sum[7:0];
		lo_idx = 5'(PTR_BASE + 5'({ptr_wr_i.sel, 1'b0}));
		if (ptr_wr_i.en)
		begin
			next_regs[lo_idx] = ptr_wr_i.value[7:0];
			next_regs[5'(lo_idx + 5'h01)] = ptr_wr_i.value[15:8];
		end
	end

	assign zero_o = (sum[7:0] == BYTE_ZERO);
	assign carry_o = sum[8];

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			for (int i = 0; i < 32; i++)
				regs[i] <= BYTE_ZERO;
		end
		else
			regs <= next_regs;
	end

	always_comb
	begin
		for (int p = 0; p < 3; p++)
			ptrs_o[p] = {regs[PTR_BASE + 2 * p + 1], regs[PTR_BASE + 2 * p]};
	end
endmodule : cisu_regs

// file: hw/cisu_agu.sv
/*
 cisu_agu: data-space address generation from one of the three pointer pairs.
 assumes the register file applies the write-back at the end of the same cycle.
*/
`timescale 1ns/1ps
module cisu_agu
(
	input cisu_pkg::cisu_agu_req_type agu_i,
	input cisu_pkg::cisu_ptrs_type ptrs_i,
	output logic [15:0] addr_o,
	output cisu_pkg::cisu_ptr_wr_type wr_o
);
	import cisu_pkg::*;

	logic [15:0] base;

	always_comb
	begin
		base = ptrs_i[agu_i.sel];
		addr_o = base;
		wr_o.en = 1'b0;
		wr_o.sel = agu_i.sel;
		wr_o.value = base;
		case (agu_i.mode)
			AGU_DISP: addr_o = base + {10'h000, agu_i.disp};
			AGU_POSTINC:
			begin
				wr_o.en = agu_i.en;
				wr_o.value = base + PTR_STEP;
			end
			AGU_PREDEC:
			begin
				addr_o = base - PTR_STEP;
				wr_o.en = agu_i.en;
				wr_o.value = base - PTR_STEP;
			end
			default: addr_o = base;
		endcase
	end
endmodule : cisu_agu

// file: hw/cisu_unit.sv
/*
 cisu_unit: interrupt entry/return sequencer, stack pointer, status and interrupt registers.
 assumes the core raises op_i and instr_done_i in an instruction's last cycle and stalls
 while busy_o; stack memory reads answer combinationally in the same cycle.
*/
`timescale 1ns/1ps
module cisu_unit
#(
	parameter int N_SRC = 8,
	parameter logic [11:0] BOOT_START = 12'he00
)
(
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input cisu_pkg::cisu_io_req_type io_i,
	output logic [7:0] io_rdata_o,
	input cisu_pkg::cisu_op_type op_i,
	input wire logic [7:0] push_data_i,
	input wire logic [cisu_pkg::PC_W-1:0] pc_i,
	input wire logic [cisu_pkg::PC_W-1:0] call_target_i,
	input wire logic instr_done_i,
	input wire logic sleeping_i,
	input wire logic [N_SRC-1:0] flag_event_i,
	input wire logic [N_SRC-1:0] level_req_i,
	input wire logic boot_reset_fuse_i,
	input wire logic app_section_lock_setting_i,
	input wire logic boot_section_lock_setting_i,
	input cisu_pkg::cisu_alu_req_type alu_i,
	input cisu_pkg::cisu_agu_req_type agu_i,
	output logic [15:0] data_addr_o,
	output cisu_pkg::cisu_mem_type mem_o,
	input wire logic [7:0] mem_rdata_i,
	output logic pc_load_o,
	output logic [cisu_pkg::PC_W-1:0] pc_value_o,
	output logic irq_ack_o,
	output logic busy_o,
	output logic [7:0] status_o
);
	import cisu_pkg::*;

	if (N_SRC < 1 || N_SRC > 8)
	begin : g_bad_n_src
		$error("cisu_unit: N_SRC must lie in 1..8");
	end

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WAKE = 3'b001,
		ST_ENTRY = 3'b011,
		ST_RETURN = 3'b010,
		ST_BOOT = 3'b110,
		ST_RVEC = 3'b111
	} cisu_state_type;

	function automatic logic [IDX_W-1:0] first_one(input logic [N_SRC-1:0] v);
		logic [IDX_W-1:0] r;
		r = '0;
		for (int i = N_SRC - 1; i >= 0; i--)
			if (v[i])
				r = IDX_W'(i);
		return r;
	endfunction : first_one

	cisu_state_type state, next_state;
	logic [2:0] cnt, next_cnt;
	logic [15:0] sp, next_sp;
	logic [7:0] status, next_status;
	logic [7:0] gen_ctrl, next_gen_ctrl;
	logic [N_SRC-1:0] irq_en, next_irq_en;
	logic [N_SRC-1:0] flag, next_flag;
	logic [IDX_W-1:0] src, next_src;
	logic src_flag, next_src_flag;
	logic kind_irq, next_kind_irq;
	logic kind_interrupt_return_instruction, next_kind_interrupt_return_instruction;
	logic [PC_W-1:0] ret_pc, next_ret_pc;
	logic [PC_W-1:0] target, next_target;
	logic [7:0] pop_hi, next_pop_hi;
	logic [PC_W-1:0] pc_value, next_pc_value;
	logic [7:0] rdata, next_rdata;
	logic [N_SRC-1:0] req;
	logic [IDX_W-1:0] win;
	logic lock_blk, take, in_boot, entry_last, return_last;
	logic [PC_W-1:0] vec_base;
	logic alu_zero, alu_carry;
	cisu_ptrs_type ptrs;
	cisu_ptr_wr_type ptr_wr;

	cisu_regs u_regs (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.alu_i(alu_i),
		.ptr_wr_i(ptr_wr),
		.zero_o(alu_zero),
		.carry_o(alu_carry),
		.ptrs_o(ptrs)
	);

	cisu_agu u_agu (
		.agu_i(agu_i),
		.ptrs_i(ptrs),
		.addr_o(data_addr_o),
		.wr_o(ptr_wr)
	);

	// request, blocking and priority
	assign req = (flag | level_req_i) & irq_en;
	assign win = first_one(req);
	assign in_boot = (pc_i >= BOOT_START);
	assign lock_blk = (app_section_lock_setting_i & ~in_boot & gen_ctrl[VSEL_BIT])
		| (boot_section_lock_setting_i & in_boot & ~gen_ctrl[VSEL_BIT]);
	// ops in flight and the current gie register keep sei and return boundaries clean
	assign take = (state == ST_IDLE) & instr_done_i & status[GIE_BIT] & ~op_i.cli
		& ~op_i.call & ~op_i.ret & ~op_i.interrupt_return_instruction & ~lock_blk & (|req);
	assign vec_base = gen_ctrl[VSEL_BIT] ? BOOT_START : APP_START;
	assign entry_last = (state == ST_ENTRY) && (cnt == ENTRY_CYC - 3'h1);
	assign return_last = (state == ST_RETURN) && (cnt == RETURN_CYC - 3'h1);

	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		next_sp = sp;
		next_status = status;
		next_gen_ctrl = gen_ctrl;
		next_irq_en = irq_en;
		next_flag = flag;
		next_src = src;
		next_src_flag = src_flag;
		next_kind_irq = kind_irq;
		next_kind_interrupt_return_instruction = kind_interrupt_return_instruction;
		next_ret_pc = ret_pc;
		next_target = target;
		next_pop_hi = pop_hi;
		next_pc_value = pc_value;
		next_rdata = rdata;
		mem_o = '0;
		if (io_i.rd)
		begin
			case (io_i.addr)
				IO_SP_LOW: next_rdata = sp[7:0];
				IO_SP_HIGH: next_rdata = sp[15:8];
				IO_STATUS: next_rdata = status;
				IO_GEN_CTRL: next_rdata = gen_ctrl;
				IO_IRQ_EN: next_rdata = 8'(irq_en);
				IO_IRQ_FLAG: next_rdata = 8'(flag);
				default: next_rdata = BYTE_ZERO;
			endcase
		end
		if (io_i.wr)
		begin
			case (io_i.addr)
				IO_SP_LOW: next_sp[7:0] = io_i.wdata;
				IO_SP_HIGH: next_sp[15:8] = io_i.wdata;
				IO_STATUS: next_status = io_i.wdata;
				IO_GEN_CTRL: next_gen_ctrl = io_i.wdata;
				IO_IRQ_EN: next_irq_en = io_i.wdata[N_SRC-1:0];
				IO_IRQ_FLAG: next_flag = flag & ~io_i.wdata[N_SRC-1:0];
				default: next_rdata = rdata;
			endcase
		end
		if (alu_i.en)
		begin
			next_status[ZERO_BIT] = alu_zero;
			next_status[CARRY_BIT] = alu_carry;
		end
		case (state)
			ST_BOOT:
			begin
				next_pc_value = boot_reset_fuse_i ? BOOT_START : APP_START;
				next_state = ST_RVEC;
			end
			ST_RVEC: next_state = ST_IDLE;
			ST_IDLE:
			begin
				next_cnt = '0;
				if (op_i.push)
				begin
					mem_o.we = 1'b1;
					mem_o.addr = sp;
					mem_o.wdata = push_data_i;
					next_sp = sp - SP_BYTE_STEP;
				end
				else if (op_i.pop)
				begin
					mem_o.re = 1'b1;
					mem_o.addr = sp + SP_BYTE_STEP;
					next_sp = sp + SP_BYTE_STEP;
				end
				if (op_i.sei)
					next_status[GIE_BIT] = 1'b1;
				if (op_i.cli)
					next_status[GIE_BIT] = 1'b0;
				if (op_i.call)
				begin
					next_kind_irq = 1'b0;
					next_ret_pc = pc_i;
					next_target = call_target_i;
					next_state = ST_ENTRY;
				end
				else if (op_i.ret || op_i.interrupt_return_instruction)
				begin
					next_kind_interrupt_return_instruction = op_i.interrupt_return_instruction;
					next_state = ST_RETURN;
				end
				else if (take)
				begin
					next_kind_irq = 1'b1;
					next_src = win;
					next_src_flag = flag[win];
					next_ret_pc = pc_i;
					next_target = 12'(vec_base + 12'(VEC_STEP * (win + 1'b1)));
					next_status[GIE_BIT] = 1'b0;
					next_state = sleeping_i ? ST_WAKE : ST_ENTRY;
				end
			end
			ST_WAKE:
			begin
				next_cnt = cnt + 3'h1;
				if (cnt == WAKE_EXTRA_CYC - 3'h1)
				begin
					next_cnt = '0;
					next_state = ST_ENTRY;
				end
			end
			ST_ENTRY:
			begin
				next_cnt = cnt + 3'h1;
				if (cnt < 3'h2)
				begin
					mem_o.we = 1'b1;
					mem_o.addr = sp;
					mem_o.wdata = (cnt == 3'h0) ? ret_pc[7:0] : 8'(ret_pc >> 8);
					next_sp = sp - SP_BYTE_STEP;
				end
				if (cnt == ENTRY_CYC - 3'h2)
					next_pc_value = target;
				if (entry_last)
				begin
					if (kind_irq && src_flag)
						next_flag[src] = 1'b0;
					next_state = ST_IDLE;
				end
			end
			ST_RETURN:
			begin
				next_cnt = cnt + 3'h1;
				if (cnt < 3'h2)
				begin
					mem_o.re = 1'b1;
					mem_o.addr = sp + SP_BYTE_STEP;
					next_sp = sp + SP_BYTE_STEP;
				end
				if (cnt == 3'h0)
					next_pop_hi = mem_rdata_i;
				if (cnt == 3'h1)
					next_pc_value = PC_W'({pop_hi, mem_rdata_i});
				if (return_last)
				begin
					if (kind_interrupt_return_instruction)
						next_status[GIE_BIT] = 1'b1;
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
		next_flag = next_flag | flag_event_i;
	end

	always_ff @(posedge ref_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			state <= ST_BOOT;
			cnt <= '0;
			sp <= SP_RESET;
			status <= BYTE_ZERO;
			gen_ctrl <= BYTE_ZERO;
			irq_en <= '0;
			flag <= '0;
			src <= '0;
			src_flag <= 1'b0;
			kind_irq <= 1'b0;
			kind_interrupt_return_instruction <= 1'b0;
			ret_pc <= APP_START;
			target <= APP_START;
			pop_hi <= BYTE_ZERO;
			pc_value <= APP_START;
			rdata <= BYTE_ZERO;
		end
		else
		begin
			state <= next_state;
			cnt <= next_cnt;
			sp <= next_sp;
			status <= next_status;
			gen_ctrl <= next_gen_ctrl;
			irq_en <= next_irq_en;
			flag <= next_flag;
			src <= next_src;
			src_flag <= next_src_flag;
			kind_irq <= next_kind_irq;
			kind_interrupt_return_instruction <= next_kind_interrupt_return_instruction;
			ret_pc <= next_ret_pc;
			target <= next_target;
			pop_hi <= next_pop_hi;
			pc_value <= next_pc_value;
			rdata <= next_rdata;
		end
	end

	assign pc_load_o = entry_last | return_last | (state == ST_RVEC);
	assign pc_value_o = pc_value;
	assign irq_ack_o = entry_last & kind_irq;
	assign busy_o = (state != ST_IDLE);
	assign status_o = status;
	assign io_rdata_o = rdata;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	entry_length_a: assert property (take && !sleeping_i |-> ##4 irq_ack_o)
		else $error("vector not reached four cycles after take");
	entry_sp_a: assert property (take && !sleeping_i && !op_i.push && !op_i.pop
		|-> ##3 (sp == $past(sp, 3) - 16'h0002))
		else $error("entry did not lower stack pointer by two");
	wake_delay_a: assert property (take && sleeping_i |-> !irq_ack_o [*8] ##1 irq_ack_o)
		else $error("wake entry not four cycles longer");
	return_length_a: assert property (state == ST_IDLE && op_i.interrupt_return_instruction && !op_i.call
		|-> ##4 pc_load_o ##1 status[GIE_BIT])
		else $error("return not four cycles or enable not set");
	gie_clear_a: assert property (take |=> !status[GIE_BIT])
		else $error("global enable kept on entry");
	cli_block_a: assert property (state == ST_IDLE && op_i.cli && !op_i.call
		|=> state != ST_ENTRY && state != ST_WAKE)
		else $error("interrupt taken with disable instruction");
	enable_gate_a: assert property (take |-> status[GIE_BIT] && (req[win] && irq_en[win]))
		else $error("taken without enables");
	prio_first_a: assert property (take && req[0] |=> src == '0)
		else $error("request zero not preferred");
	push_step_a: assert property (state == ST_IDLE && op_i.push && !io_i.wr
		|=> sp == $past(sp) - 16'h0001)
		else $error("push did not lower stack pointer by one");
	pop_step_a: assert property (state == ST_IDLE && op_i.pop && !op_i.push && !io_i.wr
		|=> sp == $past(sp) + 16'h0001)
		else $error("pop did not raise stack pointer by one");
	flag_clear_a: assert property (irq_ack_o && src_flag && !flag_event_i[src]
		|=> !flag[$past(src)])
		else $error("flag not cleared on vectoring");

	irq_entry_c: cover property (take ##4 irq_ack_o);
	interrupt_return_instruction_seq_c: cover property (state == ST_IDLE && op_i.interrupt_return_instruction ##4 pc_load_o);
	wake_entry_c: cover property (take && sleeping_i);
	nested_c: cover property (irq_ack_o ##[1:20] take);
endmodule : cisu_unit

// file: tb/cisu_stack_mem.sv
/*
 cisu_stack_mem: data memory model standing behind the unit's stack port.
 assumes stack addresses below 0x400; reads answer in the same cycle as the request.
*/
`timescale 1ns/1ps
module cisu_stack_mem
(
	input wire logic ref_clk_i,
	input cisu_pkg::cisu_mem_type mem_i,
	output logic [7:0] rdata_o
);
	import cisu_pkg::*;
	logic [7:0] store [0:1023];
	logic [7:0] last = 8'h00;
	always_ff @(posedge ref_clk_i)
	begin
		if (mem_i.we)
			store[mem_i.addr[9:0]] <= mem_i.wdata;
		if (mem_i.re)
			last <= store[mem_i.addr[9:0]];
	end
	// released data lines never repeat the last byte
	assign rdata_o = mem_i.re ? store[mem_i.addr[9:0]] : ~last;
endmodule : cisu_stack_mem

// file: tb/cisu_unit_tb_top.sv
/*
 cisu_unit_tb_top: self-checking bench for the interrupt and stack unit.
 assumes inputs driven on falling edges and the stack memory model on the memory port.
*/
`timescale 1ns/1ps
module cisu_unit_tb_top;
	import cisu_pkg::*;
	localparam logic [11:0] BOOT = 12'he00;
	localparam cisu_op_type OP_PUSH = '{push: 1'b1, default: 1'b0};
	localparam cisu_op_type OP_POP = '{pop: 1'b1, default: 1'b0};
	localparam cisu_op_type OP_CALL = '{call: 1'b1, default: 1'b0};
	localparam cisu_op_type OP_RET = '{ret: 1'b1, default: 1'b0};
	localparam cisu_op_type OP_INTERRUPT_RETURN_INSTRUCTION = '{interrupt_return_instruction: 1'b1, default: 1'b0};
	localparam cisu_op_type OP_SEI = '{sei: 1'b1, default: 1'b0};
	localparam cisu_op_type OP_CLI = '{cli: 1'b1, default: 1'b0};
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	cisu_io_req_type io_i = '0;
	cisu_op_type op_i = '0;
	logic [7:0] push_data_i = 8'h00;
	logic [11:0] pc_i = 12'h000;
	logic [11:0] call_target_i = 12'h000;
	logic instr_done_i = 1'b0;
	logic sleeping_i = 1'b0;
	logic [7:0] flag_event_i = 8'h00;
	logic [7:0] level_req_i = 8'h00;
	logic boot_fuse = 1'b0;
	logic app_lock = 1'b0;
	logic boot_lock = 1'b0;
	cisu_mem_type mem_o;
	logic [7:0] mem_rdata_i, io_rdata_o, status_o;
	logic [11:0] pc_value_o;
	logic pc_load_o, irq_ack_o, busy_o;
	cisu_alu_req_type alu_i = '0;
	cisu_agu_req_type agu_i = '0;
	logic [15:0] data_addr_o;
	int error_cnt = 0;
	int comparisons = 0;

	always #12.5 ref_clk_i = ~ref_clk_i;

	cisu_unit #(.N_SRC(8), .BOOT_START(BOOT)) DUT
	(
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .io_i(io_i), .io_rdata_o(io_rdata_o),
		.op_i(op_i), .push_data_i(push_data_i), .pc_i(pc_i), .call_target_i(call_target_i),
		.instr_done_i(instr_done_i), .sleeping_i(sleeping_i), .flag_event_i(flag_event_i),
		.level_req_i(level_req_i), .boot_reset_fuse_i(boot_fuse),
		.app_section_lock_setting_i(app_lock), .boot_section_lock_setting_i(boot_lock),
		.alu_i(alu_i), .agu_i(agu_i), .data_addr_o(data_addr_o), .mem_o(mem_o),
		.mem_rdata_i(mem_rdata_i),
		.pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .irq_ack_o(irq_ack_o),
		.busy_o(busy_o), .status_o(status_o)
	);

	cisu_stack_mem PEER (.ref_clk_i(ref_clk_i), .mem_i(mem_o), .rdata_o(mem_rdata_i));

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic io_wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge ref_clk_i);
		io_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(negedge ref_clk_i);
		io_i = '0;
	endtask : io_wr

	task automatic chk_io(input string what, input logic [5:0] a, input logic [7:0] exp);
		@(negedge ref_clk_i);
		io_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge ref_clk_i);
		io_i = '0;
		check(what, {8'h00, exp}, {8'h00, io_rdata_o});
	endtask : chk_io

	task automatic chk_sp(input logic [15:0] exp);
		chk_io("stack pointer low", IO_SP_LOW, exp[7:0]);
		chk_io("stack pointer high", IO_SP_HIGH, exp[15:8]);
	endtask : chk_sp

	task automatic pulse(input cisu_op_type o, input logic done);
		@(negedge ref_clk_i);
		op_i = o;
		instr_done_i = done;
		@(negedge ref_clk_i);
		op_i = '0;
		instr_done_i = 1'b0;
	endtask : pulse

	task automatic raise(input logic [7:0] f);
		@(negedge ref_clk_i);
		flag_event_i = f;
		@(negedge ref_clk_i);
		flag_event_i = 8'h00;
	endtask : raise

	// counts falling edges since the request edge until the load pulse
	task automatic wait_load(input string what, input int n_exp, input logic [11:0] pc_exp,
		input logic ack_exp);
		int n;
		n = 1;
		while (pc_load_o !== 1'b1 && n < 40)
		begin
			@(negedge ref_clk_i);
			n++;
		end
		check({what, " cycles"}, 16'(n_exp), 16'(n));
		check({what, " target"}, {4'h0, pc_exp}, {4'h0, pc_value_o});
		check({what, " ack"}, {15'h0, ack_exp}, {15'h0, irq_ack_o});
		check({what, " busy"}, 16'h0001, {15'h0, busy_o});
	endtask : wait_load

	task automatic alu_op(input cisu_alu_op_type o, input logic [4:0] d, input logic [4:0] s,
		input logic [7:0] k);
		@(negedge ref_clk_i);
		alu_i = '{en: 1'b1, op: o, dst: d, src: s, imm: k};
		@(negedge ref_clk_i);
		alu_i = '0;
	endtask : alu_op

	// effective address settles well before the edge that writes the pointer back
	task automatic agu_step(input cisu_agu_mode_type m, input logic [5:0] k,
		input logic [15:0] exp);
		@(negedge ref_clk_i);
		agu_i = '{en: 1'b1, sel: 2'h0, mode: m, disp: k};
		#1;
		check("data address", exp, data_addr_o);
		@(negedge ref_clk_i);
		agu_i = '0;
	endtask : agu_step

	task automatic no_load(input string what, input int cyc);
		repeat (cyc)
		begin
			@(negedge ref_clk_i);
			check(what, 16'h0000, {15'h0, pc_load_o});
		end
	endtask : no_load

	task automatic interrupt_return_instruction_back();
		pulse(OP_INTERRUPT_RETURN_INSTRUCTION, 1'b0);
		wait_load("return", 4, pc_i, 1'b0);
	endtask : interrupt_return_instruction_back

	task automatic t_reset(input logic fz);
		@(negedge ref_clk_i);
		rst_i = 1'b1;
		boot_fuse = fz;
		repeat (16) @(negedge ref_clk_i);
		rst_i = 1'b0;
		wait_load("reset vector", 2, fz ? BOOT : 12'h000, 1'b0);
		chk_sp(16'h0000);
		chk_io("status", IO_STATUS, 8'h00);
	endtask : t_reset

	task automatic t_stack();
		io_wr(IO_SP_HIGH, 8'h01);
		io_wr(IO_SP_LOW, 8'h00);
		chk_sp(16'h0100);
		push_data_i = 8'ha5;
		pulse(OP_PUSH, 1'b1);
		chk_sp(16'h00ff);
		check("pushed byte", 16'h00a5, {8'h00, PEER.store[10'h100]});
		pulse(OP_POP, 1'b1);
		chk_sp(16'h0100);
		pc_i = 12'h123;
		call_target_i = 12'h456;
		pulse(OP_CALL, 1'b1);
		wait_load("call", 4, 12'h456, 1'b0);
		chk_sp(16'h00fe);
		pulse(OP_RET, 1'b1);
		wait_load("subroutine return", 4, 12'h123, 1'b0);
		chk_sp(16'h0100);
	endtask : t_stack

	task automatic t_irq();
		io_wr(IO_IRQ_EN, 8'h05);
		raise(8'h05);
		pulse('0, 1'b1);
		no_load("take while disabled", 6);
		chk_io("pending flags", IO_IRQ_FLAG, 8'h05);
		io_wr(IO_STATUS, 8'h83);
		pc_i = 12'h200;
		pulse('0, 1'b1);
		wait_load("first vector", 4, 12'h001, 1'b1);
		chk_io("status after entry", IO_STATUS, 8'h03);
		chk_io("flags after entry", IO_IRQ_FLAG, 8'h04);
		chk_sp(16'h00fe);
		interrupt_return_instruction_back();
		chk_io("status after return", IO_STATUS, 8'h83);
		chk_sp(16'h0100);
		pulse('0, 1'b1);
		wait_load("second vector", 4, 12'h003, 1'b1);
		interrupt_return_instruction_back();
	endtask : t_irq

	task automatic t_gate();
		raise(8'h01);
		pulse(OP_CLI, 1'b1);
		no_load("take beside disable", 8);
		chk_io("status after disable", IO_STATUS, 8'h03);
		pulse(OP_SEI, 1'b1);
		no_load("take beside enable", 6);
		pulse('0, 1'b1);
		wait_load("after enable", 4, 12'h001, 1'b1);
		interrupt_return_instruction_back();
		raise(8'h02);
		pulse('0, 1'b1);
		no_load("source disabled", 6);
		io_wr(IO_IRQ_FLAG, 8'h02);
		chk_io("flag written clear", IO_IRQ_FLAG, 8'h00);
	endtask : t_gate

	task automatic t_level();
		pulse(OP_CLI, 1'b0);
		level_req_i = 8'h04;
		pulse('0, 1'b1);
		no_load("level while disabled", 4);
		level_req_i = 8'h00;
		pulse(OP_SEI, 1'b0);
		pulse('0, 1'b1);
		no_load("level gone", 6);
		level_req_i = 8'h04;
		pulse('0, 1'b1);
		wait_load("level vector", 4, 12'h003, 1'b1);
		level_req_i = 8'h00;
		interrupt_return_instruction_back();
	endtask : t_level

	task automatic t_vectors();
		io_wr(IO_GEN_CTRL, 8'h02);
		raise(8'h01);
		pulse('0, 1'b1);
		wait_load("moved vector", 4, BOOT + 12'h001, 1'b1);
		interrupt_return_instruction_back();
		app_lock = 1'b1;
		raise(8'h01);
		pulse('0, 1'b1);
		no_load("application lock", 6);
		app_lock = 1'b0;
		pulse('0, 1'b1);
		wait_load("unlocked vector", 4, BOOT + 12'h001, 1'b1);
		interrupt_return_instruction_back();
		io_wr(IO_GEN_CTRL, 8'h00);
		boot_lock = 1'b1;
		pc_i = 12'he10;
		raise(8'h01);
		pulse('0, 1'b1);
		no_load("boot lock", 6);
		boot_lock = 1'b0;
		pc_i = 12'h200;
		sleeping_i = 1'b1;
		pulse('0, 1'b1);
		wait_load("wake vector", 8, 12'h001, 1'b1);
		sleeping_i = 1'b0;
		interrupt_return_instruction_back();
	endtask : t_vectors

	task automatic t_alu();
		alu_op(ALU_LDI, 5'h1a, 5'h00, 8'h34);
		alu_op(ALU_LDI, 5'h1b, 5'h00, 8'h12);
		agu_step(AGU_DISP, 6'h05, 16'h1239);
		agu_step(AGU_POSTINC, 6'h00, 16'h1234);
		agu_step(AGU_PLAIN, 6'h00, 16'h1235);
		agu_step(AGU_PREDEC, 6'h00, 16'h1234);
		agu_step(AGU_PLAIN, 6'h00, 16'h1234);
		alu_op(ALU_LDI, 5'h10, 5'h00, 8'hff);
		alu_op(ALU_LDI, 5'h11, 5'h00, 8'h01);
		alu_op(ALU_ADD, 5'h10, 5'h11, 8'h00);
		check("zero and carry", 16'h0003, {14'h0, status_o[1:0]});
		alu_op(ALU_MOV, 5'h1a, 5'h10, 8'h00);
		agu_step(AGU_PLAIN, 6'h00, 16'h1200);
	endtask : t_alu

	initial
	begin
		t_reset(1'b0);
		t_stack();
		t_irq();
		t_gate();
		t_level();
		t_vectors();
		t_alu();
		t_reset(1'b1);
		complete_run();
	end

	// run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge ref_clk_i);
		error_cnt++;
		$display("watchdog expired");
		complete_run();
	end
endmodule : cisu_unit_tb_top
